// ===== hw/cable_bridge_regs.svh
// register offsets, field positions and timing counts of the cable bridge
// Notes on behaviour
// [R1] four host locations: data port, board pointer, bus reset, one unassigned
// [R2] pointer write sets the board address used by later data accesses
// [R3] pointer keeps its value until the host writes the pointer again
// [R4] a pointer write finishes on the host bus in under 10 us
// [R5] pointer read: address in bits 5..0, read/write bit 6, busy bit 7
// [R6] address is latched so an immediate read returns the value written
// [R7] status bits read as the inverted cable control signal levels
// [R8] idle status bits read zero, so readback equals stored address
// [R9] each data port write becomes a cable byte write to the selected board; the code drops writes made during a cable operation
// [R10] each data port read does a cable read and returns the board's byte; the code drops reads made during a cable operation
// [R11] remote output boards latch written bytes and return them on read
// [R12] any write to the reset port drives a reset pulse onto the cable; the code drops writes made during a cable operation
// [R13] host waits 20 ms after a bus reset before further accesses
// [R14] host polls pointer, masking with 192, until both status bits are zero
// [R15] base of the four locations is switch-selected within 512 to 1023
// [R16] busy stands from start of each cable transfer or reset until done
// [R17] unassigned location has no effect; its reads return an undefined value
`ifndef CABLE_BRIDGE_REGS_SVH
`define CABLE_BRIDGE_REGS_SVH
`define OFS_DATA_PORT 2'h0
`define OFS_BOARD_PTR 2'h1
`define OFS_BUS_RESET 2'h2
`define OFS_UNASSIGNED 2'h3
`define PTR_RW_BIT 6
`define PTR_BUSY_BIT 7
`define PTR_RESET 6'h00
`define IO_RANGE_LO 10'h200
`define IO_RANGE_HI 10'h3FF
`define CLK_MHZ 10
`define PTR_WRITE_US 10
`define PTR_WRITE_CYC ((`PTR_WRITE_US * `CLK_MHZ) - 1)
`define BUS_RESET_MS 20
`define BUS_RESET_CYC (`BUS_RESET_MS * 1000 * `CLK_MHZ)
`define STROBE_NS 2000
`define STROBE_CYC ((`STROBE_NS * `CLK_MHZ) / 1000)
`endif

// ===== hw/cable_bridge_pkg.sv
// types shared by the cable bridge modules
package cable_bridge_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WRITE = 2'b01,
		ST_READ = 2'b10,
		ST_RESET = 2'b11
	} bridge_state_type;

	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] data_out;
		logic [7:0] data_oe;
		logic strobe_b;
		logic rw_b;
		logic reset_b;
	} cable_drive_type;
endpackage

// ===== hw/pin_sync.sv
// three-stage synchroniser; change accepted when stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// pins
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1, s2, s3;
	wire [WIDTH-1:0] agree = ~(s2 ^ s3);
	wire [WIDTH-1:0] next_level = (agree & s3) | (~agree & level);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			level <= '0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			level <= next_level;
		end
	end
endmodule

// ===== hw/op_timer.sv
// down counter giving the length of a cable strobe or reset pulse
`timescale 1ns/100ps
module op_timer #(
	parameter int WIDTH = 18
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// control
	input wire logic load,
	input wire logic [WIDTH-1:0] count,
	output logic done
);
	logic [WIDTH-1:0] remain;
	wire running = (remain != '0);
	wire [WIDTH-1:0] next_remain = load ? count :
		running ? remain - WIDTH'(1) : remain;

	assign done = running && (remain == WIDTH'(1)) && !load;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			remain <= '0;
		else
			remain <= next_remain;
	end
endmodule

// ===== hw/cable_bridge.sv
// host i/o to parallel cable bus bridge, top level
`timescale 1ns/100ps
`include "cable_bridge_regs.svh"
module cable_bridge
	import cable_bridge_pkg::*;
#(
	parameter int BUS_RESET_CYCLES = `BUS_RESET_CYC,
	parameter int STROBE_CYCLES = `STROBE_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// base address switch
	input wire logic [9:2] base_switch,
	// host i/o bus, one-cycle strobes
	input wire logic [9:0] host_addr,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	output logic host_ready,
	// cable bus
	output logic [5:0] cable_addr,
	output logic [7:0] cable_data_out,
	output logic cable_data_oe,
	input wire logic [7:0] cable_data_in,
	output logic cable_strobe_b,
	output logic cable_rw_b,
	output logic cable_reset_b
);
	localparam int TW = 18;

	bridge_state_type state;
	cable_drive_type drive;
	logic [5:0] board_ptr;
	logic [7:0] switch_base;
	logic [7:0] read_byte;
	logic pending_rd;
	logic timer_done;
	logic [7:0] data_sync;

	// base strap caught after reset release, held thereafter
	logic strap_taken;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			strap_taken <= 1'b0;
			switch_base <= 8'h00;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			switch_base <= base_switch;
		end
	end

	wire [9:0] base_full = {switch_base, 2'b00};
	wire base_legal = (base_full >= `IO_RANGE_LO) &&
		(base_full <= `IO_RANGE_HI); // R15
	wire hit = strap_taken && base_legal &&
		(host_addr[9:2] == switch_base); // R1 R15
	wire [1:0] ofs = host_addr[1:0];
	wire idle = (state == ST_IDLE);
	// data and reset port accesses during a cable operation are dropped; host must poll first
	wire wr_data = hit && host_wr && idle && (ofs == `OFS_DATA_PORT); // R9
	wire rd_data = hit && host_rd && idle && (ofs == `OFS_DATA_PORT); // R10
	wire wr_ptr = hit && host_wr && (ofs == `OFS_BOARD_PTR); // R2
	wire rd_ptr = hit && host_rd && (ofs == `OFS_BOARD_PTR);
	wire wr_rst = hit && host_wr && idle && (ofs == `OFS_BUS_RESET); // R12
	// location three starts no cable action; its reads return 8'hFF
	wire rd_other = hit && host_rd && (ofs == `OFS_UNASSIGNED); // R17

	// pointer readback: status bits are inverted active-low cable levels
	wire stat_busy = ~drive.strobe_b | ~drive.reset_b; // R7 R16
	wire stat_rw = ~drive.rw_b; // R7
	wire [7:0] ptr_view = {stat_busy, stat_rw, board_ptr}; // R5 R8

	wire load_timer = wr_data | rd_data | wr_rst;
	wire [TW-1:0] load_count = wr_rst ? TW'(BUS_RESET_CYCLES) :
		TW'(STROBE_CYCLES);

	op_timer #(.WIDTH(TW)) u_timer (
		.mclk(mclk),
		.rst_b(rst_b),
		.load(load_timer),
		.count(load_count),
		.done(timer_done)
	);

	pin_sync #(.WIDTH(8)) u_sync (
		.mclk(mclk),
		.rst_b(rst_b),
		.pin(cable_data_in),
		.level(data_sync)
	);

	bridge_state_type next_state;
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (wr_rst)
					next_state = ST_RESET; // R12
				else if (wr_data)
					next_state = ST_WRITE; // R9
				else if (rd_data)
					next_state = ST_READ; // R10
			end
			ST_WRITE, ST_READ, ST_RESET: begin
				if (timer_done)
					next_state = ST_IDLE; // R16
			end
		endcase
	end

	// answer two cycles after the strobe ends: the synchroniser needs
	// that long to carry the board byte, and it still holds it then
	wire strobe_end_rd = (state == ST_READ) && timer_done;
	logic [1:0] rd_tail;
	wire read_end = rd_tail[1]; // R10
	wire [7:0] next_rdata = rd_ptr ? ptr_view :
		read_end ? data_sync : rd_other ? 8'hFF : host_rdata; // R17
	wire next_ready = rd_ptr | wr_ptr | rd_other |
		(hit && host_wr && (ofs != `OFS_BOARD_PTR)) | read_end; // R4

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			board_ptr <= `PTR_RESET;
			pending_rd <= 1'b0;
			rd_tail <= 2'b00;
			read_byte <= 8'h00;
			host_rdata <= 8'h00;
			host_ready <= 1'b0;
		end else begin
			state <= next_state;
			if (wr_ptr)
				board_ptr <= host_wdata[5:0]; // R2 R3 R6
			pending_rd <= rd_data | (pending_rd & ~read_end);
			rd_tail <= {rd_tail[0], strobe_end_rd};
			if (read_end)
				read_byte <= data_sync; // R10
			host_rdata <= next_rdata;
			host_ready <= next_ready; // R4
		end
	end

	// cable drive image, registered so every pin is a flip-flop
	logic [7:0] wr_byte;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wr_byte <= 8'h00;
			drive <= '{addr: 6'h00, data_out: 8'h00, data_oe: 8'h00,
				strobe_b: 1'b1, rw_b: 1'b1, reset_b: 1'b1};
		end else begin
			if (wr_data)
				wr_byte <= host_wdata;
			drive.addr <= board_ptr; // R2
			drive.data_out <= wr_data ? host_wdata : wr_byte;
			drive.data_oe <= (next_state == ST_WRITE) ? 8'hFF : 8'h00;
			drive.strobe_b <= !((next_state == ST_WRITE) ||
				(next_state == ST_READ)); // R9 R10 R16
			drive.rw_b <= !(next_state == ST_READ); // R10
			drive.reset_b <= !(next_state == ST_RESET); // R12
		end
	end

	assign cable_addr = drive.addr;
	assign cable_data_out = drive.data_out;
	assign cable_data_oe = drive.data_oe[0];
	assign cable_strobe_b = drive.strobe_b;
	assign cable_rw_b = drive.rw_b;
	assign cable_reset_b = drive.reset_b;

	AST_PTR_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
		!wr_ptr |=> $stable(board_ptr)) // R3
		else $error("pointer changed without a pointer write");
	AST_PTR_READBACK: assert property (@(posedge mclk) disable iff (!rst_b)
		wr_ptr ##1 rd_ptr |=> host_rdata[5:0] == $past(host_wdata[5:0], 2))
		// R6
		else $error("pointer readback differs from value written");
	AST_IDLE_STATUS: assert property (@(posedge mclk) disable iff (!rst_b)
		rd_ptr && drive.strobe_b && drive.reset_b |=>
		host_rdata[7:6] == 2'b00) // R8
		else $error("status bits set while idle");
	AST_PTR_FAST: assert property (@(posedge mclk) disable iff (!rst_b)
		wr_ptr |=> host_ready) // R4
		else $error("pointer write not acknowledged");
	AST_WRITE_STROBE: assert property (@(posedge mclk) disable iff (!rst_b)
		wr_data |=> !cable_strobe_b && cable_rw_b &&
		cable_data_out == $past(host_wdata)) // R9
		else $error("data write not forwarded");
	AST_READ_STROBE: assert property (@(posedge mclk) disable iff (!rst_b)
		rd_data |=> !cable_strobe_b && !cable_rw_b) // R10
		else $error("data read not forwarded");
	AST_RESET_PULSE: assert property (@(posedge mclk) disable iff (!rst_b)
		wr_rst |=> !cable_reset_b [*8]) // R12
		else $error("bus reset pulse missing");
	AST_BUSY_BIT: assert property (@(posedge mclk) disable iff (!rst_b)
		rd_ptr |=> host_rdata[7] == $past(stat_busy)) // R16
		else $error("busy bit wrong on pointer read");
	AST_UNASSIGNED: assert property (@(posedge mclk) disable iff (!rst_b)
		hit && host_wr && ofs == `OFS_UNASSIGNED |=>
		$stable(state) && $stable(board_ptr)) // R17
		else $error("unassigned write changed state");
	AST_RANGE: assert property (@(posedge mclk) disable iff (!rst_b)
		hit |-> base_full >= `IO_RANGE_LO) // R15
		else $error("decode below legal range");

	COV_WRITE: cover property (@(posedge mclk) disable iff (!rst_b)
		wr_data);
	COV_READ: cover property (@(posedge mclk) disable iff (!rst_b)
		read_end);
	COV_RESET: cover property (@(posedge mclk) disable iff (!rst_b)
		wr_rst);
	COV_BUSY_POLL: cover property (@(posedge mclk) disable iff (!rst_b)
		rd_ptr && stat_busy);
endmodule

// ===== test/remote_board_model.sv
// behavioural model of the remote boards on the cable bus
`timescale 1ns/100ps
module remote_board_model (
	// cable from the bridge
	input wire logic [5:0] cable_addr,
	input wire logic [7:0] cable_data_out,
	input wire logic cable_data_oe,
	input wire logic cable_strobe_b,
	input wire logic cable_rw_b,
	input wire logic cable_reset_b,
	// cable to the bridge
	output logic [7:0] cable_data_in
);
	logic [7:0] mem [64];
	logic [7:0] last = 8'h00;
	initial cable_data_in = 8'hff;
	always @(negedge cable_reset_b)
		foreach (mem[i]) mem[i] <= 8'h00;
	// sample a little after the strobe falls so the bus has settled
	always @(negedge cable_strobe_b) begin
		#10;
		if (cable_rw_b && cable_data_oe && cable_reset_b)
			mem[cable_addr] = cable_data_out;
	end
	// released bus shows the inverse so a stale byte cannot pass
	always @(cable_strobe_b or cable_rw_b or cable_addr) begin
		if (!cable_strobe_b && !cable_rw_b) begin
			last = mem[cable_addr];
			cable_data_in = last;
		end else begin
			cable_data_in = ~last;
		end
	end
endmodule

// ===== test/cable_bridge_tb.sv
// self-checking bench for the cable bridge
`timescale 1ns/100ps
`define CHECK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
	$display("mismatch %s expected %h seen %h", nm, exp, got); \
	fail_count++; end end
module cable_bridge_tb;
	localparam logic [9:0] BASE = 10'h300;
	localparam logic [9:0] PTR = 10'h301;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [9:2] base_switch = 8'hc0;
	logic [9:0] host_addr = 10'h000;
	logic host_wr = 1'b0;
	logic host_rd = 1'b0;
	logic [7:0] host_wdata = 8'h00;
	logic [7:0] host_rdata, cable_data_out, cable_data_in, rd;
	logic host_ready, cable_data_oe, cable_strobe_b, cable_rw_b, cable_reset_b;
	logic [5:0] cable_addr;
	int fail_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int lat;
	bit ok, saw_rd;
	cable_bridge #(.BUS_RESET_CYCLES(20), .STROBE_CYCLES(4)) DUT (.mclk,
		.rst_b, .base_switch, .host_addr, .host_wr, .host_rd, .host_wdata,
		.host_rdata, .host_ready, .cable_addr, .cable_data_out, .cable_data_oe,
		.cable_data_in, .cable_strobe_b, .cable_rw_b, .cable_reset_b);
	remote_board_model boards (.cable_addr, .cable_data_out, .cable_data_oe,
		.cable_strobe_b, .cable_rw_b, .cable_reset_b, .cable_data_in);
	initial begin
		forever #50 mclk = ~mclk;
	end
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	// one-cycle strobe, then wait for the answer
	task automatic access(input bit wr, input logic [9:0] a,
		input logic [7:0] d);
		ok = 0;
		@(posedge mclk);
		host_addr <= a;
		host_wdata <= d;
		if (wr)
			host_wr <= 1'b1;
		else
			host_rd <= 1'b1;
		@(posedge mclk);
		host_wr <= 1'b0;
		host_rd <= 1'b0;
		for (lat = 1; lat < 1000 && !ok; lat++) begin
			@(negedge mclk);
			if (cable_strobe_b === 1'b0 && cable_rw_b === 1'b0)
				saw_rd = 1;
			if (host_ready === 1'b1) begin
				ok = 1;
				rd = host_rdata;
			end
		end
	endtask
	task automatic poll_idle();
		int n;
		n = 0;
		do begin
			access(0, PTR, 8'h00);
			n++;
		end while (rd[7:6] !== 2'b00 && n < 50);
	endtask
	task automatic test_done(input string nm);
		$display("test %s done", nm);
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (2) @(posedge mclk);
		access(0, PTR, 8'h00);
		`CHECK("ptr after reset", 8'h00, rd)
		access(1, PTR, 8'hff);
		`CHECK("ptr write time", 1'b1, ok && lat <= 100)
		access(0, PTR, 8'h00);
		`CHECK("ptr upper bits", 8'h3f, rd)
		access(1, PTR, 8'h05);
		access(0, PTR, 8'h00);
		`CHECK("ptr readback", 8'h05, rd)
		test_done("pointer");
		access(1, BASE, 8'ha5);
		`CHECK("cable write", {6'h05, 8'ha5, 3'b011}, {cable_addr,
			cable_data_out, cable_strobe_b, cable_rw_b, cable_data_oe})
		access(0, PTR, 8'h00);
		`CHECK("busy on write", 8'h85, rd)
		poll_idle();
		`CHECK("idle status", 8'h05, rd)
		access(1, PTR, 8'h06);
		poll_idle();
		access(1, BASE, 8'h3c);
		poll_idle();
		access(1, PTR, 8'h05);
		poll_idle();
		saw_rd = 0;
		access(0, BASE, 8'h00);
		`CHECK("read board 5", 8'ha5, rd)
		`CHECK("read cycle seen", 1'b1, saw_rd)
		access(1, PTR, 8'h06);
		poll_idle();
		access(0, BASE, 8'h00);
		`CHECK("read board 6", 8'h3c, rd)
		poll_idle();
		`CHECK("ptr held", 8'h06, rd)
		test_done("data");
		access(1, BASE + 10'h2, 8'h00);
		`CHECK("reset pulse", 1'b0, cable_reset_b)
		access(0, PTR, 8'h00);
		`CHECK("busy on reset", 8'h86, rd)
		repeat (25) @(posedge mclk);
		poll_idle();
		access(0, BASE, 8'h00);
		`CHECK("board cleared", 8'h00, rd)
		test_done("reset");
		poll_idle();
		access(1, BASE + 10'h3, 8'h3f);
		`CHECK("spare no cycle", 1'b1, cable_strobe_b)
		access(0, BASE + 10'h3, 8'h00);
		`CHECK("spare read", 8'hff, rd)
		access(1, 10'h305, 8'h11);
		`CHECK("other base", 1'b0, ok)
		access(0, PTR, 8'h00);
		`CHECK("ptr untouched", 8'h06, rd)
		test_done("decode");
		end_of_test();
	end
endmodule
